// [common/slcr_pkg.sv]
// package for the serdes lane configuration register bank
package slcr_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] TX_CFG_OFFSET = 4'h0;
  localparam logic [3:0] RX_CFG_OFFSET = 4'h4;
  localparam logic [3:0] TX_STAT_OFFSET = 4'h8;
  localparam logic [3:0] RX_STAT_OFFSET = 4'hC;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // writable bit masks per register
  localparam logic [31:0] TX_WR_MASK = 32'h0001_FFFF;
  localparam logic [31:0] RX_WR_MASK = 32'h037F_FFFF;
  localparam int TX_EN_BIT = 0;
  localparam int TX_RSV_BIT = 1;
  localparam int TX_WIDTH_LSB = 2;
  localparam int TX_RATE_LSB = 5;
  localparam int TX_SWING_LSB = 9;
  localparam int TX_DE_LSB = 12;
  localparam int RX_LOS_LSB = 14;
  localparam int RX_CDR_LSB = 16;
  localparam int RX_EQ_LSB = 19;
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [1:0] LOS_OFF = 2'h0;
  localparam logic [1:0] LOS_HIGH = 2'h1;
  localparam logic [1:0] LOS_LOW = 2'h2;

  typedef enum logic [1:0] {
    SLCR_DIV1 = 2'b00,
    SLCR_DIV2 = 2'b01,
    SLCR_DIV4 = 2'b10,
    SLCR_DIVX = 2'b11
  } slcr_rate_e;

  typedef struct packed {
    logic transmitter_on;
    logic [1:0] rate_div;
    logic rate_valid;
    logic [3:0] deemphasis_level;
    logic [2:0] swing;
    logic width_ok;
  } slcr_tx_s;

  typedef struct packed {
    logic [3:0] equalizer_setting;
    logic second_order;
    logic fast_lock;
    logic [1:0] cdr_profile;
    logic los_enable;
    logic los_high;
    logic los_valid;
  } slcr_rx_s;
endpackage

// [core/slcr_regs.sv]
// register bank for one serial lane transmit and receive configuration
// Overview of operation
// RULE1: rate field picks full, half or quarter pll rate; 11b reserved
// RULE2: software keeps transmit bus width at zero for ten-bit bus
// RULE3: software writes zero to transmit bit 1
// RULE4: transmit bit 0 turns the lane transmitter on or off
// RULE5: four-bit de-emphasis picks amplitude reduction, zero means none
// RULE6: three-bit swing picks one of eight output amplitudes
// RULE7: receive bits 31 to 26 read as zero
// RULE8: software writes zero to receive bits 25 and 24
// RULE9: receive bit 23 reads as zero
// RULE10: bits 22 to 19 configure the adaptive equalizer
// RULE11: recovery code zero is first order tracking
// RULE12: recovery codes 1 to 3 are second order variants
// RULE13: recovery code 4 is first order with fast lock
// RULE14: recovery codes 5 to 7 are codes 1 to 3 with fast lock
// RULE15: loss-of-signal code zero disables detection
// RULE16: loss code 1 high threshold, 2 low threshold, 3 reserved
`timescale 1ns/100ps
`default_nettype none
module slcr_regs (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic TX_ENABLE_OUT,
  output logic [1:0] TX_RATE_DIV_OUT,
  output logic [3:0] TX_DEEMPH_OUT,
  output logic [2:0] TX_SWING_OUT,
  output logic [3:0] RX_EQ_OUT,
  output logic RX_CDR_SECOND_OUT,
  output logic RX_CDR_FAST_OUT,
  output logic [1:0] RX_CDR_PROFILE_OUT,
  output logic RX_LOS_EN_OUT,
  output logic RX_LOS_HIGH_OUT,
  output logic CFG_ERROR_OUT
);
  logic [31:0] tx_cfg;
  logic [31:0] rx_cfg;
  logic [31:0] next_tx_cfg;
  logic [31:0] next_rx_cfg;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  slcr_pkg::slcr_tx_s tx_ctl;
  slcr_pkg::slcr_rx_s rx_ctl;
  slcr_pkg::slcr_tx_s tx_q;
  slcr_pkg::slcr_rx_s rx_q;
  logic err;
  logic next_err;
  logic tx_on;
  logic next_tx_on;

  slcr_tx_decode u_tx (
    .cfg_in(tx_cfg),
    .ctl_out(tx_ctl)
  );

  slcr_rx_decode u_rx (
    .cfg_in(rx_cfg),
    .ctl_out(rx_ctl)
  );

  always_comb begin
    next_tx_cfg = tx_cfg;
    next_rx_cfg = rx_cfg;
    if (WR_IN) begin
      if (ADDR_IN == slcr_pkg::TX_CFG_OFFSET) begin
        // reserved bits stored as written so misuse is visible
        next_tx_cfg = WDATA_IN & slcr_pkg::TX_WR_MASK; // RULE2 RULE3
      end
      if (ADDR_IN == slcr_pkg::RX_CFG_OFFSET) begin
        // 25:24 writable, 31:26 and 23 forced zero
        next_rx_cfg = WDATA_IN & slcr_pkg::RX_WR_MASK; // RULE7 RULE8 RULE9
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (RD_IN) begin
      case (ADDR_IN)
        slcr_pkg::TX_CFG_OFFSET: next_rdata = tx_cfg;
        slcr_pkg::RX_CFG_OFFSET: next_rdata = rx_cfg; // RULE7 RULE9
        slcr_pkg::TX_STAT_OFFSET: begin
          next_rdata[0] = tx_q.transmitter_on;
          next_rdata[1] = tx_q.rate_valid;
          next_rdata[2] = tx_q.width_ok;
          next_rdata[5:4] = tx_q.rate_div;
        end
        slcr_pkg::RX_STAT_OFFSET: begin
          next_rdata[0] = rx_q.second_order;
          next_rdata[1] = rx_q.fast_lock;
          next_rdata[2] = rx_q.los_enable;
          next_rdata[3] = rx_q.los_high;
          next_rdata[4] = rx_q.los_valid;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // configuration error seen by the lane: reserved codes in use
  always_comb begin
    next_err = ~tx_ctl.rate_valid | ~tx_ctl.width_ok | ~rx_ctl.los_valid
      | tx_cfg[slcr_pkg::TX_RSV_BIT] | (rx_cfg[25:24] != 2'h0);
    // reserved rate code holds the transmitter off
    next_tx_on = tx_ctl.transmitter_on & tx_ctl.rate_valid; // RULE4 RULE1
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      tx_cfg <= slcr_pkg::CFG_RESET;
      rx_cfg <= slcr_pkg::CFG_RESET;
      rdata <= 32'h0000_0000;
      tx_q <= '0;
      rx_q <= '0;
      err <= 1'b0;
      tx_on <= 1'b0;
    end else begin
      tx_cfg <= next_tx_cfg;
      rx_cfg <= next_rx_cfg;
      rdata <= next_rdata;
      tx_q <= tx_ctl;
      rx_q <= rx_ctl;
      err <= next_err;
      tx_on <= next_tx_on;
    end
  end

  // outputs registered; lane sees a change two cycles after the write
  always_comb begin
    RDATA_OUT = rdata;
    TX_ENABLE_OUT = tx_on; // RULE4 RULE1
    TX_RATE_DIV_OUT = tx_q.rate_div; // RULE1
    TX_DEEMPH_OUT = tx_q.deemphasis_level; // RULE5
    TX_SWING_OUT = tx_q.swing; // RULE6
    RX_EQ_OUT = rx_q.equalizer_setting; // RULE10
    RX_CDR_SECOND_OUT = rx_q.second_order; // RULE12
    RX_CDR_FAST_OUT = rx_q.fast_lock; // RULE13
    RX_CDR_PROFILE_OUT = rx_q.cdr_profile; // RULE14
    RX_LOS_EN_OUT = rx_q.los_enable; // RULE15
    RX_LOS_HIGH_OUT = rx_q.los_high; // RULE16
    CFG_ERROR_OUT = err;
  end
endmodule
`default_nettype wire

// [core/slcr_rx_decode.sv]
// decoder from receive configuration word to lane controls
`timescale 1ns/100ps
`default_nettype none
module slcr_rx_decode (
  input wire logic [31:0] cfg_in,
  output var slcr_pkg::slcr_rx_s ctl_out
);
  logic [2:0] cdr;
  logic [1:0] los;
  assign cdr = cfg_in[slcr_pkg::RX_CDR_LSB +: 3];
  assign los = cfg_in[slcr_pkg::RX_LOS_LSB +: 2];
  always_comb begin
    ctl_out.equalizer_setting = cfg_in[slcr_pkg::RX_EQ_LSB +: 4]; // RULE10
    // code 0 first order, 4 first order fast lock
    ctl_out.second_order = (cdr[1:0] != 2'h0); // RULE11 RULE12
    ctl_out.fast_lock = cdr[2]; // RULE13 RULE14
    ctl_out.cdr_profile = cdr[1:0]; // RULE14
    ctl_out.los_enable = 1'b0;
    ctl_out.los_high = 1'b0;
    ctl_out.los_valid = 1'b1;
    case (los) // RULE15 RULE16
      slcr_pkg::LOS_OFF: ctl_out.los_enable = 1'b0;
      slcr_pkg::LOS_HIGH: begin
        ctl_out.los_enable = 1'b1;
        ctl_out.los_high = 1'b1;
      end
      slcr_pkg::LOS_LOW: ctl_out.los_enable = 1'b1;
      // reserved code keeps detection off
      default: ctl_out.los_valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [core/slcr_tx_decode.sv]
// decoder from transmit configuration word to lane controls
`timescale 1ns/100ps
`default_nettype none
module slcr_tx_decode (
  input wire logic [31:0] cfg_in,
  output var slcr_pkg::slcr_tx_s ctl_out
);
  always_comb begin
    ctl_out.transmitter_on = cfg_in[slcr_pkg::TX_EN_BIT]; // RULE4
    ctl_out.deemphasis_level = cfg_in[slcr_pkg::TX_DE_LSB +: 4]; // RULE5
    ctl_out.swing = cfg_in[slcr_pkg::TX_SWING_LSB +: 3]; // RULE6
    // width other than ten bits is flagged, not acted on
    ctl_out.width_ok = (cfg_in[slcr_pkg::TX_WIDTH_LSB +: 3] == 3'h0);
    case (cfg_in[slcr_pkg::TX_RATE_LSB +: 2]) // RULE1
      slcr_pkg::RATE_FULL: begin
        ctl_out.rate_div = slcr_pkg::SLCR_DIV1;
        ctl_out.rate_valid = 1'b1;
      end
      slcr_pkg::RATE_HALF: begin
        ctl_out.rate_div = slcr_pkg::SLCR_DIV2;
        ctl_out.rate_valid = 1'b1;
      end
      slcr_pkg::RATE_QUARTER: begin
        ctl_out.rate_div = slcr_pkg::SLCR_DIV4;
        ctl_out.rate_valid = 1'b1;
      end
      default: begin
        ctl_out.rate_div = slcr_pkg::SLCR_DIVX;
        ctl_out.rate_valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// [dv/slcr_lane_model.sv]
// behavioural analog lane consuming the transmit controls
`timescale 1ns/100ps
`default_nettype none
module slcr_lane_model (
  input wire logic en_in,
  input wire logic [1:0] rate_in,
  output logic [2:0] div_out
);
  // an idle or reserved lane shows no divider at all
  always_comb begin
    div_out = 3'h0;
    if (en_in && rate_in != 2'h3) begin
      div_out = 3'h1 << rate_in;
    end
  end
endmodule
`default_nettype wire

// [dv/slcr_regs_monitor.sv]
// port checker for the lane configuration register bank
`timescale 1ns/100ps
`default_nettype none
module slcr_regs_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic TX_ENABLE_OUT,
  input wire logic [1:0] TX_RATE_DIV_OUT,
  input wire logic [3:0] TX_DEEMPH_OUT,
  input wire logic [3:0] RX_EQ_OUT,
  input wire logic RX_CDR_SECOND_OUT,
  input wire logic [1:0] RX_CDR_PROFILE_OUT,
  input wire logic RX_LOS_EN_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);
  // idle read bus stays zero so a stale word never looks valid
  rd_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
    else $error("read data outside its slot");
  rx_zero_a: assert property (
    $past(RD_IN) && $past(ADDR_IN) == 4'h4 |->
    RDATA_OUT[31:26] == 6'h0 && !RDATA_OUT[23]) else $error("rx zeros");
  en_rate_a: assert property (
    TX_ENABLE_OUT |-> TX_RATE_DIV_OUT != 2'h3) else $error("bad rate on");
  tx_word_a: assert property (WR_IN && ADDR_IN == 4'h0 |-> ##2
    TX_ENABLE_OUT == ($past(WDATA_IN[0], 2) && $past(WDATA_IN[6:5], 2) != 2'h3)
    && TX_DEEMPH_OUT == $past(WDATA_IN[15:12], 2)) else $error("tx word");
  tx_rate_a: assert property (WR_IN && ADDR_IN == 4'h0 |-> ##2
    TX_RATE_DIV_OUT == $past(WDATA_IN[6:5], 2)) else $error("tx rate");
  rx_eq_a: assert property (WR_IN && ADDR_IN == 4'h4 |-> ##2
    RX_EQ_OUT == $past(WDATA_IN[22:19], 2)) else $error("equalizer");
  cdr_kind_a: assert property (
    RX_CDR_SECOND_OUT == (RX_CDR_PROFILE_OUT != 2'h0)) else $error("cdr");
  los_mode_a: assert property (WR_IN && ADDR_IN == 4'h4 |->
    ##2 RX_LOS_EN_OUT == ^$past(WDATA_IN[15:14], 2)) else $error("los enable");
  cover property (RD_IN && ADDR_IN == 4'h4);
  cover property (WR_IN ##1 WR_IN);
  cover property (TX_ENABLE_OUT && TX_RATE_DIV_OUT == 2'h2);
endmodule
`default_nettype wire

// [dv/slcr_regs_tb.sv]
// self-checking bench for the lane configuration register bank
`timescale 1ns/100ps
`default_nettype none
module slcr_regs_tb;
  logic SYS_CLK_IN = 1'b0;
  logic SRST_IN = 1'b1;
  logic WR_IN = 1'b0;
  logic RD_IN = 1'b0;
  logic [3:0] ADDR_IN = 4'h0;
  logic [31:0] WDATA_IN = 32'h0;
  logic [31:0] RDATA_OUT;
  logic [1:0] TX_RATE_DIV_OUT, RX_CDR_PROFILE_OUT;
  logic [3:0] TX_DEEMPH_OUT, RX_EQ_OUT;
  logic [2:0] TX_SWING_OUT, div;
  logic TX_ENABLE_OUT, RX_CDR_SECOND_OUT, RX_CDR_FAST_OUT;
  logic RX_LOS_EN_OUT, RX_LOS_HIGH_OUT, CFG_ERROR_OUT;
  int fails = 0;
  int tests_run = 0;
  wire logic [31:0] tx_o = {22'h0, TX_ENABLE_OUT, TX_RATE_DIV_OUT,
    TX_DEEMPH_OUT, TX_SWING_OUT};
  wire logic [31:0] rx_o = {21'h0, RX_EQ_OUT, RX_CDR_SECOND_OUT,
    RX_CDR_FAST_OUT, RX_CDR_PROFILE_OUT, RX_LOS_EN_OUT, RX_LOS_HIGH_OUT,
    CFG_ERROR_OUT};
  // tx word, rx word, then expected enable and error
  logic [65:0] rows [9] = '{{32'h0000F001, 32'h0, 2'h2},
    {32'h00000E21, 32'h00794000, 2'h2}, {32'h00000041, 32'h00028000, 2'h2},
    {32'h00000061, 32'h00030000, 2'h1}, {32'h0, 32'h0004C000, 2'h1},
    {32'h00000003, 32'h00050000, 2'h3},
    {32'h00000005, 32'h00060000, 2'h3},
    {32'hFFFF0001, 32'hFC870000, 2'h2},
    {32'h00001001, 32'h01000000, 2'h3}};
  always #2 SYS_CLK_IN = ~SYS_CLK_IN;
  slcr_regs dut_u (.SYS_CLK_IN, .SRST_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
    .RD_IN, .RDATA_OUT, .TX_ENABLE_OUT, .TX_RATE_DIV_OUT, .TX_DEEMPH_OUT,
    .TX_SWING_OUT, .RX_EQ_OUT, .RX_CDR_SECOND_OUT, .RX_CDR_FAST_OUT,
    .RX_CDR_PROFILE_OUT, .RX_LOS_EN_OUT, .RX_LOS_HIGH_OUT, .CFG_ERROR_OUT);
  slcr_lane_model lane_u (.en_in(TX_ENABLE_OUT), .rate_in(TX_RATE_DIV_OUT),
    .div_out(div));
  task end_sim;
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input logic w, input logic r, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge SYS_CLK_IN);
    WR_IN <= w;
    RD_IN <= r;
    ADDR_IN <= a;
    WDATA_IN <= d;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    cyc(1'b0, 1'b1, a, 32'h0);
    cyc(1'b0, 1'b0, a, 32'h0);
    #1 cmp(RDATA_OUT, exp);
  endtask
  initial begin
    logic [31:0] tx, rx, et, er;
    logic en, err;
    repeat (2) @(posedge SYS_CLK_IN);
    SRST_IN <= 1'b0;
    #1 cmp(tx_o | rx_o, 32'h0);
    rd(4'h0, slcr_pkg::CFG_RESET);
    rd(4'h4, slcr_pkg::CFG_RESET);
    for (int i = 0; i < 9; i++) begin
      {tx, rx, en, err} = rows[i];
      cyc(1'b1, 1'b0, 4'h0, tx);
      cyc(1'b1, 1'b0, 4'h4, rx);
      repeat (3) cyc(1'b0, 1'b0, 4'h0, 32'h0);
      et = {22'h0, en, tx[6:5], tx[15:12], tx[11:9]};
      er = {21'h0, rx[22:19], |rx[17:16], rx[18], rx[17:16], ^rx[15:14],
        rx[15:14] == 2'h1, err};
      #1 cmp(tx_o, et);
      cmp(rx_o, er);
      cmp({29'h0, div}, en ? 32'h1 << tx[6:5] : 32'h0);
      rd(4'h0, tx & slcr_pkg::TX_WR_MASK);
      rd(4'h4, rx & slcr_pkg::RX_WR_MASK);
      et = {26'h0, tx[6:5], 1'b0, tx[4:2] == 3'h0, tx[6:5] != 2'h3, tx[0]};
      rd(4'h8, et);
      er = {27'h0, rx[15:14] != 2'h3, rx[15:14] == 2'h1, ^rx[15:14], rx[18],
        |rx[17:16]};
      rd(4'hC, er);
    end
    cyc(1'b1, 1'b0, 4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h0);
    @(posedge SYS_CLK_IN);
    SRST_IN <= 1'b1;
    repeat (2) @(posedge SYS_CLK_IN);
    SRST_IN <= 1'b0;
    #1 cmp(tx_o | rx_o, 32'h0);
    rd(4'h4, 32'h0);
    end_sim();
  end
  initial begin
    #20000;
    fails++;
    end_sim();
  end
endmodule
bind slcr_regs slcr_regs_monitor mon_u (.SYS_CLK_IN, .SRST_IN, .ADDR_IN,
  .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .TX_ENABLE_OUT, .TX_RATE_DIV_OUT,
  .TX_DEEMPH_OUT, .RX_EQ_OUT, .RX_CDR_SECOND_OUT, .RX_CDR_PROFILE_OUT,
  .RX_LOS_EN_OUT);
`default_nettype wire
